// File: hdl/clkctl_pkg.sv
// Package with register map, field layouts and timing constants of the clock control block.
package clkctl_pkg;

  // Register offsets are not multiples of four, so they are indices.
  localparam logic [7:0] IDX_MISC    = 8'h05;
  localparam logic [7:0] IDX_CLOCK   = 8'h06;
  localparam logic [7:0] IDX_RATIO   = 8'h07;
  localparam logic [7:0] IDX_RXSTAT  = 8'h08;
  localparam logic [7:0] IDX_FREEZE0 = 8'h0F;
  localparam logic [7:0] IDX_FREEZE1 = 8'h1B;

  localparam logic [7:0] MISC_RESET  = 8'h00;
  localparam logic [7:0] CLOCK_RESET = 8'h00;
  localparam logic [7:0] MISC_WMASK  = 8'hDF;

  // Field positions of the miscellaneous register.
  localparam int MISC_EXT_SCLK  = 7;
  localparam int MISC_TRISTATE  = 6;
  localparam int MISC_FREEZE    = 4;
  localparam int MISC_ROLLOFF   = 3;
  localparam int MISC_HP_HOLD   = 2;
  localparam int MISC_CODEC_MS  = 1;
  localparam int MISC_AUX_MS    = 0;

  // Field positions of the clock register.
  localparam int CLK_DIV_LSB    = 6;
  localparam int CLK_RANGE_LSB  = 4;
  localparam int CLK_FRAME_LOCK = 3;
  localparam int CLK_SRC_LSB    = 1;
  localparam int CLK_FORCED     = 0;

  localparam logic [1:0] RANGE_RESERVED = 2'h3;
  localparam logic [2:0] RXCLK_FORCED   = 3'h7;
  localparam logic [2:0] FMT_LAST_VALID = 3'h4;

  typedef enum logic [1:0] {SRC_PLL, SRC_EXT, SRC_HOLD, SRC_AUTO} src_sel_t;
  typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4, MUL_2} div_sel_t;

  // Receiver data zero run that means silence.
  localparam int SILENCE_RUN = 1548;

  // Serial port clock dividers: bit clock half period in master clock enables, frame half period in bit clocks.
  localparam int BCLK_HALF   = 4;
  localparam int FRAME_BCLKS = 32;

  typedef struct packed {
    logic ext_sclk;
    logic tristate;
    logic freeze;
    logic rolloff;
    logic hp_hold;
    logic codec_master;
    logic aux_master;
  } misc_t;

  typedef struct packed {
    logic bit_clk;
    logic frame_clk;
  } port_clk_t;

endpackage : clkctl_pkg

// File: hdl/codec_clock_and_misc_control.sv
// Clock selection, serial port timing and status registers of the audio codec.
`timescale 1ns/10ps
module codec_clock_and_misc_control #(
  parameter int SILENCE_RUN = clkctl_pkg::SILENCE_RUN
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock recovery status from the receiver and PLL
  input  wire logic        pll_unlock,
  input  wire logic [7:0]  measured_ratio,
  input  wire logic [2:0]  measured_rx_clk,
  input  wire logic [2:0]  rx_format_code,
  input  wire logic        rx_sample_valid,
  input  wire logic        rx_sample_zero,
  input  wire logic        mclk_tick,
  input  wire logic        pll_mclk_x2_tick,
  // Serial port pins
  input  wire logic        codec_bit_clock_in,
  input  wire logic        codec_frame_clock_in,
  output logic             codec_bit_clock_out,
  output logic             codec_frame_clock_out,
  output logic             codec_port_oe,
  input  wire logic        aux_bit_clock_in,
  input  wire logic        aux_frame_clock_in,
  output logic             aux_bit_clock_out,
  output logic             aux_frame_clock_out,
  output logic             aux_port_oe,
  output logic             ext_adc_bit_clock,
  // Recovered clock pin
  output logic             recovered_clk_out,
  output logic             recovered_clk_oe,
  // Controls to the converter datapath
  output logic             use_ext_clock,
  output logic             pll_ref_is_frame,
  output logic             sample_rate_autodetect,
  output logic             interp_rolloff_select,
  output logic             highpass_hold,
  output logic             freeze_active,
  output logic             apply_pending,
  output logic [1:0]       ext_clock_range,
  output logic [1:0]       recovered_clk_divider
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0]  misc_r, misc_nxt;
  logic [7:0]  clock_r, clock_nxt;
  logic [7:0]  index;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rx_status;
  logic [7:0]  ratio_view;
  logic        forced;

  assign index   = paddr[9:2];
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign forced  = clock_r[clkctl_pkg::CLK_FORCED];

  always_comb begin
    misc_nxt  = misc_r;
    clock_nxt = clock_r;
    if (wr_en && index == clkctl_pkg::IDX_MISC) begin
      misc_nxt = pwdata[7:0] & clkctl_pkg::MISC_WMASK;
    end
    if (wr_en && index == clkctl_pkg::IDX_CLOCK) begin
      clock_nxt = pwdata[7:0];
      // A reserved range code leaves the previous range in place.
      if (pwdata[clkctl_pkg::CLK_RANGE_LSB +: 2] == clkctl_pkg::RANGE_RESERVED) begin
        clock_nxt[clkctl_pkg::CLK_RANGE_LSB +: 2] =
          clock_r[clkctl_pkg::CLK_RANGE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_r  <= clkctl_pkg::MISC_RESET;
      clock_r <= clkctl_pkg::CLOCK_RESET;
    end else begin
      misc_r  <= misc_nxt;
      clock_r <= clock_nxt;
    end
  end

  // Addresses in the frozen range belong to other blocks; writes there answer OKAY
  // here so that the freeze sequence never sees a bus error, while reads get one.
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (index)
        clkctl_pkg::IDX_MISC:   prdata = {24'h00_0000, misc_r};
        clkctl_pkg::IDX_CLOCK:  prdata = {24'h00_0000, clock_r};
        clkctl_pkg::IDX_RATIO:  prdata = {24'h00_0000, ratio_view};
        clkctl_pkg::IDX_RXSTAT: prdata = {24'h00_0000, rx_status};
        default: begin
          if (index < clkctl_pkg::IDX_FREEZE0 || index > clkctl_pkg::IDX_FREEZE1 || rd_en) begin
            pslverr = 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain settings
  assign interp_rolloff_select = misc_r[clkctl_pkg::MISC_ROLLOFF];
  assign highpass_hold         = misc_r[clkctl_pkg::MISC_HP_HOLD];
  assign ext_clock_range       = clock_r[clkctl_pkg::CLK_RANGE_LSB +: 2];
  assign recovered_clk_divider = clock_r[clkctl_pkg::CLK_DIV_LSB +: 2];
  assign pll_ref_is_frame      = clock_r[clkctl_pkg::CLK_FRAME_LOCK];
  assign sample_rate_autodetect = !forced;
  assign freeze_active         = misc_r[clkctl_pkg::MISC_FREEZE];
  // One pulse when freeze falls tells the datapath to apply all held writes.
  assign apply_pending = misc_r[clkctl_pkg::MISC_FREEZE] &&
                         !misc_nxt[clkctl_pkg::MISC_FREEZE];

  ////////////////////////////////////////////////////////////////////////////
  // Master clock source selection
  logic src_ext_r, src_ext_nxt;

  always_comb begin
    src_ext_nxt = src_ext_r;
    unique case (clkctl_pkg::src_sel_t'(clock_r[clkctl_pkg::CLK_SRC_LSB +: 2]))
      clkctl_pkg::SRC_PLL:  src_ext_nxt = 1'b0;
      clkctl_pkg::SRC_EXT:  src_ext_nxt = 1'b1;
      clkctl_pkg::SRC_HOLD: src_ext_nxt = src_ext_r;
      clkctl_pkg::SRC_AUTO: src_ext_nxt = pll_unlock;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ext_r <= 1'b0;
    end else begin
      src_ext_r <= src_ext_nxt;
    end
  end

  // With manual PLL and lost lock the external clock is passed on, unless
  // lock is forced, in which case the pin keeps following the PLL.
  assign use_ext_clock = src_ext_r || (pll_unlock && !forced);

  ////////////////////////////////////////////////////////////////////////////
  // Recovered clock output divider
  logic [2:0] rdiv_r, rdiv_nxt;
  logic       src_tick;
  logic       rclk_r, rclk_nxt;

  assign src_tick = (clkctl_pkg::div_sel_t'(recovered_clk_divider) == clkctl_pkg::MUL_2)
                    ? pll_mclk_x2_tick : mclk_tick;

  always_comb begin
    rdiv_nxt = rdiv_r;
    rclk_nxt = rclk_r;
    if (src_tick) begin
      rdiv_nxt = rdiv_r + 3'h1;
      unique case (clkctl_pkg::div_sel_t'(recovered_clk_divider))
        clkctl_pkg::DIV_1: rclk_nxt = !rclk_r;
        clkctl_pkg::MUL_2: rclk_nxt = !rclk_r;
        clkctl_pkg::DIV_2: rclk_nxt = rdiv_r[0] ? !rclk_r : rclk_r;
        clkctl_pkg::DIV_4: rclk_nxt = (rdiv_r[1:0] == 2'h3) ? !rclk_r : rclk_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdiv_r <= 3'h0;
      rclk_r <= 1'b0;
    end else begin
      rdiv_r <= rdiv_nxt;
      rclk_r <= rclk_nxt;
    end
  end

  assign recovered_clk_out = rclk_r;
  assign recovered_clk_oe  = !misc_r[clkctl_pkg::MISC_TRISTATE];

  ////////////////////////////////////////////////////////////////////////////
  // Serial port clock generators, one per port
  logic [1:0] port_master;
  clkctl_pkg::port_clk_t [1:0] port_out;
  clkctl_pkg::port_clk_t [1:0] port_in;

  assign port_master = {misc_r[clkctl_pkg::MISC_CODEC_MS], misc_r[clkctl_pkg::MISC_AUX_MS]};
  assign port_in[1]  = '{bit_clk: codec_bit_clock_in, frame_clk: codec_frame_clock_in};
  assign port_in[0]  = '{bit_clk: aux_bit_clock_in, frame_clk: aux_frame_clock_in};

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [2:0] bdiv_r, bdiv_nxt;
      logic [5:0] fdiv_r, fdiv_nxt;
      clkctl_pkg::port_clk_t clk_r, clk_nxt;

      always_comb begin
        bdiv_nxt = bdiv_r;
        fdiv_nxt = fdiv_r;
        clk_nxt  = clk_r;
        if (!port_master[p]) begin
          bdiv_nxt = 3'h0;
          fdiv_nxt = 6'h00;
          clk_nxt  = '0;
        end else if (mclk_tick) begin
          if (bdiv_r == 3'(clkctl_pkg::BCLK_HALF - 1)) begin
            bdiv_nxt = 3'h0;
            clk_nxt.bit_clk = !clk_r.bit_clk;
            if (clk_r.bit_clk) begin
              if (fdiv_r == 6'(clkctl_pkg::FRAME_BCLKS - 1)) begin
                fdiv_nxt = 6'h00;
                clk_nxt.frame_clk = !clk_r.frame_clk;
              end else begin
                fdiv_nxt = fdiv_r + 6'h01;
              end
            end
          end else begin
            bdiv_nxt = bdiv_r + 3'h1;
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bdiv_r <= 3'h0;
          fdiv_r <= 6'h00;
          clk_r  <= '0;
        end else begin
          bdiv_r <= bdiv_nxt;
          fdiv_r <= fdiv_nxt;
          clk_r  <= clk_nxt;
        end
      end

      assign port_out[p] = clk_r;
    end
  endgenerate

  assign codec_bit_clock_out   = port_out[1].bit_clk;
  assign codec_frame_clock_out = port_out[1].frame_clk;
  assign codec_port_oe         = port_master[1];
  assign aux_bit_clock_out     = port_out[0].bit_clk;
  assign aux_frame_clock_out   = port_out[0].frame_clk;
  assign aux_port_oe           = port_master[0];

  // In slave mode the port relies on the far side supplying its clocks.
  logic codec_bclk, aux_bclk;
  assign codec_bclk = port_master[1] ? port_out[1].bit_clk : port_in[1].bit_clk;
  assign aux_bclk   = port_master[0] ? port_out[0].bit_clk : port_in[0].bit_clk;
  assign ext_adc_bit_clock = misc_r[clkctl_pkg::MISC_EXT_SCLK] ? codec_bclk : aux_bclk;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver status
  logic [10:0] zrun_r, zrun_nxt;
  logic        silence_r, silence_nxt;
  logic [2:0]  fmt_r, fmt_nxt;

  always_comb begin
    zrun_nxt    = zrun_r;
    silence_nxt = silence_r;
    fmt_nxt     = (rx_format_code > clkctl_pkg::FMT_LAST_VALID) ? fmt_r : rx_format_code;
    if (rx_sample_valid) begin
      if (!rx_sample_zero) begin
        zrun_nxt    = 11'h000;
        silence_nxt = 1'b0;
      end else if (zrun_r == 11'(SILENCE_RUN - 1)) begin
        silence_nxt = 1'b1;
      end else begin
        zrun_nxt = zrun_r + 11'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zrun_r    <= 11'h000;
      silence_r <= 1'b0;
      fmt_r     <= 3'h0;
    end else begin
      zrun_r    <= zrun_nxt;
      silence_r <= silence_nxt;
      fmt_r     <= fmt_nxt;
    end
  end

  // Forced lock leaves nothing to measure against, so the ratio reads zero.
  assign ratio_view = forced ? 8'h00 : measured_ratio;
  assign rx_status  = {silence_r, fmt_r, use_ext_clock,
                       forced ? clkctl_pkg::RXCLK_FORCED : measured_rx_clk};

endmodule : codec_clock_and_misc_control

// File: tb/clkctl_assertions.sv
// Checker for the register-driven outputs of the clock control block.
`timescale 1ns/10ps
module clkctl_assertions (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Controls
  input wire logic        recovered_clk_oe,
  input wire logic        codec_port_oe,
  input wire logic        aux_port_oe,
  input wire logic        use_ext_clock,
  input wire logic        pll_ref_is_frame,
  input wire logic        sample_rate_autodetect,
  input wire logic        interp_rolloff_select,
  input wire logic        highpass_hold,
  input wire logic        freeze_active,
  input wire logic        apply_pending,
  input wire logic [1:0]  ext_clock_range,
  input wire logic [1:0]  recovered_clk_divider
);
  logic wm;
  logic wc;
  assign wm = psel && penable && pwrite && paddr[9:2] == clkctl_pkg::IDX_MISC;
  assign wc = psel && penable && pwrite && paddr[9:2] == clkctl_pkg::IDX_CLOCK;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  property p_tri; wm |=> recovered_clk_oe == !$past(pwdata[6]); endproperty
  a_tri: assert property (p_tri) else $error("bad tristate");
  property p_frz; wm |=> freeze_active == $past(pwdata[4]); endproperty
  a_frz: assert property (p_frz) else $error("bad freeze");
  property p_apply; apply_pending |=> !apply_pending; endproperty
  a_apply: assert property (p_apply) else $error("apply too long");
  property p_filt;
    wm |=> {interp_rolloff_select, highpass_hold} == $past(pwdata[3:2]); endproperty
  a_filt: assert property (p_filt) else $error("bad filter bits");
  property p_ms; wm |=> {codec_port_oe, aux_port_oe} == $past(pwdata[1:0]); endproperty
  a_ms: assert property (p_ms) else $error("bad port enables");
  property p_div; wc |=> recovered_clk_divider == $past(pwdata[7:6]); endproperty
  a_div: assert property (p_div) else $error("bad divider");
  property p_rng;
    wc && pwdata[5:4] != 2'h3 |=> ext_clock_range == $past(pwdata[5:4]); endproperty
  a_rng: assert property (p_rng) else $error("bad range");
  property p_rsv; wc && pwdata[5:4] == 2'h3 |=> $stable(ext_clock_range); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved range taken");
  property p_lrck; wc |=> pll_ref_is_frame == $past(pwdata[3]); endproperty
  a_lrck: assert property (p_lrck) else $error("bad frame lock");
  property p_ext; wc && pwdata[2:0] == 3'h2 |-> ##[1:3] use_ext_clock; endproperty
  a_ext: assert property (p_ext) else $error("external source not taken");
  property p_frc; wc && pwdata[0] |=> !sample_rate_autodetect; endproperty
  a_frc: assert property (p_frc) else $error("autodetect left on");
  c_apply: cover property (apply_pending);
  c_auto: cover property (wc && pwdata[2:1] == 2'h3);
  c_frc: cover property (wc && pwdata[0]);
endmodule : clkctl_assertions

bind codec_clock_and_misc_control clkctl_assertions i_clkctl_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .recovered_clk_oe(recovered_clk_oe),
  .codec_port_oe(codec_port_oe), .aux_port_oe(aux_port_oe), .use_ext_clock(use_ext_clock),
  .pll_ref_is_frame(pll_ref_is_frame), .sample_rate_autodetect(sample_rate_autodetect),
  .interp_rolloff_select(interp_rolloff_select), .highpass_hold(highpass_hold),
  .freeze_active(freeze_active), .apply_pending(apply_pending),
  .ext_clock_range(ext_clock_range), .recovered_clk_divider(recovered_clk_divider));

// File: tb/clkctl_far_side.sv
// Far side model: master clock enables and serial port clocks for slave mode.
`timescale 1ns/10ps
module clkctl_far_side (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Clock enables and port pins
  output logic     mclk_tick,
  output logic     pll_mclk_x2_tick,
  output logic     codec_bit_clock_in,
  output logic     codec_frame_clock_in,
  output logic     aux_bit_clock_in,
  output logic     aux_frame_clock_in
);
  logic [7:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end
  assign mclk_tick = cnt_r[0];
  assign pll_mclk_x2_tick = 1'b1;
  // Bit clocks run at different rates so a wrong port choice shows up.
  assign codec_bit_clock_in = cnt_r[1];
  assign aux_bit_clock_in = cnt_r[2];
  assign codec_frame_clock_in = cnt_r[7];
  assign aux_frame_clock_in = cnt_r[6];
endmodule : clkctl_far_side

// File: tb/codec_clock_and_misc_control_tb.sv
// Self-checking bench for the clock control block.
`timescale 1ns/10ps
module codec_clock_and_misc_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, pll_unlock;
  logic rx_sample_valid, rx_sample_zero, mclk_tick, pll_mclk_x2_tick;
  logic codec_bit_clock_in, codec_frame_clock_in, aux_bit_clock_in, aux_frame_clock_in;
  logic codec_port_oe, aux_port_oe, ext_adc_bit_clock, recovered_clk_oe, use_ext_clock;
  logic sample_rate_autodetect, interp_rolloff_select, highpass_hold, freeze_active;
  logic apply_pending, pll_ref_is_frame, recovered_clk_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] measured_ratio;
  logic [2:0] measured_rx_clk, rx_format_code;
  logic [1:0] ext_clock_range, recovered_clk_divider;
  int n_fail = 0;
  int total_checks = 0;
  int n_apply = 0;
  // Entries: pll unlock after write, source code, expected external source.
  logic [3:0] src_tab [6] = '{4'h3, 4'h6, 4'hF, 4'h5, 4'h9, 4'h0};
  int tgl;
  logic prev;

  codec_clock_and_misc_control #(.SILENCE_RUN(4)) i_codec_clock_and_misc_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_unlock(pll_unlock), .measured_ratio(measured_ratio),
    .measured_rx_clk(measured_rx_clk), .rx_format_code(rx_format_code),
    .rx_sample_valid(rx_sample_valid), .rx_sample_zero(rx_sample_zero),
    .mclk_tick(mclk_tick), .pll_mclk_x2_tick(pll_mclk_x2_tick),
    .codec_bit_clock_in(codec_bit_clock_in), .codec_frame_clock_in(codec_frame_clock_in),
    .codec_bit_clock_out(), .codec_frame_clock_out(), .codec_port_oe(codec_port_oe),
    .aux_bit_clock_in(aux_bit_clock_in), .aux_frame_clock_in(aux_frame_clock_in),
    .aux_bit_clock_out(), .aux_frame_clock_out(), .aux_port_oe(aux_port_oe),
    .ext_adc_bit_clock(ext_adc_bit_clock), .recovered_clk_out(recovered_clk_out),
    .recovered_clk_oe(recovered_clk_oe), .use_ext_clock(use_ext_clock),
    .pll_ref_is_frame(pll_ref_is_frame), .sample_rate_autodetect(sample_rate_autodetect),
    .interp_rolloff_select(interp_rolloff_select), .highpass_hold(highpass_hold),
    .freeze_active(freeze_active), .apply_pending(apply_pending),
    .ext_clock_range(ext_clock_range), .recovered_clk_divider(recovered_clk_divider));

  clkctl_far_side i_clkctl_far_side (
    .pclk(pclk), .presetn(presetn), .mclk_tick(mclk_tick),
    .pll_mclk_x2_tick(pll_mclk_x2_tick), .codec_bit_clock_in(codec_bit_clock_in),
    .codec_frame_clock_in(codec_frame_clock_in), .aux_bit_clock_in(aux_bit_clock_in),
    .aux_frame_clock_in(aux_frame_clock_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) if (apply_pending === 1'b1) n_apply <= n_apply + 1;

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is sampled while it stands, before the edge that ends the access.
    do begin
      @(negedge pclk);
      n++;
      if (pready !== 1'b1) @(posedge pclk);
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      n_fail++;
      stop_test();
    end
    // Let registered outputs settle before anyone samples them.
    @(negedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [31:0] d); apb(1'b1, i, d); endtask : wr
  task automatic rd(input logic [7:0] i); apb(1'b0, i, 32'h0); endtask : rd

  task automatic sclk(input logic [7:0] v);
    int bad;
    bad = 0;
    wr(8'h05, {24'h0, v});
    repeat (12) begin
      @(negedge pclk);
      if (ext_adc_bit_clock !== (v[7] ? codec_bit_clock_in : aux_bit_clock_in)) bad++;
    end
    chk("adc bit clock", 32'(bad), 32'h0);
  endtask : sclk

  task automatic feed(input int k);
    repeat (k) begin
      @(posedge pclk);
      rx_sample_valid <= 1'b1;
      rx_sample_zero <= 1'b1;
    end
    @(posedge pclk);
    rx_sample_valid <= 1'b0;
  endtask : feed

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, pll_unlock, rx_sample_valid, rx_sample_zero} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    measured_ratio = 8'h60;
    measured_rx_clk = 3'h3;
    rx_format_code = 3'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h06);
    chk("clock reset", q, 32'h0);
    chk("rclk oe reset", 32'(recovered_clk_oe), 32'h1);
    wr(8'h05, 32'hFF);
    rd(8'h05);
    chk("misc readback", q, 32'hDF);
    chk("enables", 32'({recovered_clk_oe, codec_port_oe, aux_port_oe}), 32'h3);
    chk("filters", 32'({interp_rolloff_select, highpass_hold, freeze_active}), 32'h7);
    wr(8'h0F, 32'h55);
    chk("frozen write", 32'(err), 32'h0);
    chk("early apply", 32'(n_apply), 32'h0);
    wr(8'h05, 32'h00);
    chk("apply", 32'(n_apply), 32'h1);
    sclk(8'h80);
    sclk(8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, 32'(i) << 6);
      chk("divider", 32'(recovered_clk_divider), 32'(i));
      tgl = 0;
      prev = recovered_clk_out;
      repeat (16) begin
        @(negedge pclk);
        if (recovered_clk_out !== prev) tgl++;
        prev = recovered_clk_out;
      end
      chk("recovered toggles", 32'(tgl), (i == 3) ? 32'h10 : (32'h8 >> i));
    end
    wr(8'h06, 32'h28);
    wr(8'h06, 32'h38);
    rd(8'h06);
    chk("range readback", q, 32'h28);
    chk("range pins", 32'({ext_clock_range, pll_ref_is_frame}), 32'h5);
    for (int i = 0; i < 6; i++) begin
      wr(8'h06, {29'h0, src_tab[i][2:1], 1'b0});
      @(posedge pclk);
      pll_unlock <= src_tab[i][3];
      repeat (4) @(posedge pclk);
      rd(8'h08);
      chk("source", 32'({use_ext_clock, q[3]}), {30'h0, {2{src_tab[i][0]}}});
    end
    rd(8'h07);
    chk("ratio", q, 32'h60);
    chk("autodetect on", 32'(sample_rate_autodetect), 32'h1);
    wr(8'h06, 32'h01);
    rd(8'h07);
    chk("ratio forced", q, 32'h0);
    rd(8'h08);
    chk("rx clock forced", 32'(q[2:0]), 32'h7);
    chk("autodetect off", 32'(sample_rate_autodetect), 32'h0);
    @(posedge pclk);
    pll_unlock <= 1'b1;
    @(negedge pclk);
    chk("forced no substitute", 32'(use_ext_clock), 32'h0);
    @(posedge pclk);
    pll_unlock <= 1'b0;
    wr(8'h06, 32'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      rx_format_code <= 3'(i);
      rd(8'h08);
      chk("format", 32'(q[6:4]), (i > 4) ? 32'h4 : 32'(i));
    end
    feed(3);
    rd(8'h08);
    chk("silence early", 32'(q[7]), 32'h0);
    feed(1);
    rd(8'h08);
    chk("silence", 32'(q[7]), 32'h1);
    wr(8'h07, 32'hFF);
    chk("ratio write", 32'(err), 32'h0);
    rd(8'h07);
    chk("ratio kept", q, 32'h60);
    rd(8'h30);
    chk("unmapped", 32'(err), 32'h1);
    stop_test();
  end
endmodule : codec_clock_and_misc_control_tb
